// ===== lssc_pkg.sv
// package: register map, field layouts and reset values of the link status / slot caps bank
package lssc_pkg;

	localparam int unsigned ADDR_W = 12;

	// printed offsets are register indices; byte address is four times that
	localparam logic [ADDR_W-1:0] LINK_STATE_REPORT_IDX = 12'h052;
	localparam logic [ADDR_W-1:0] SLOT_FEATURE_CAPS_IDX = 12'h054;
	localparam logic [ADDR_W-1:0] LINK_STATE_REPORT_ADDR = 12'h148;
	localparam logic [ADDR_W-1:0] SLOT_FEATURE_CAPS_ADDR = 12'h150;
	localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR = 12'h160;
	localparam logic [ADDR_W-1:0] EVENT_MASK_ADDR = 12'h164;

	localparam logic [3:0] LINK_RATE_CODE = 4'h1;
	localparam logic [5:0] LANE_WIDTH_RST = 6'h00;
	localparam logic [2:0] EVENT_RST = 3'h0;
	localparam logic [1:0] PORT_UPSTREAM = 2'h0;

	// event bit positions
	localparam int unsigned EV_TRAIN_FAULT = 0;
	localparam int unsigned EV_MSG_SENT = 1;
	localparam int unsigned EV_LINK_UP = 2;
	localparam int unsigned EV_W = 3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		LSSC_SCALE_X1,
		LSSC_SCALE_XP1,
		LSSC_SCALE_XP01,
		LSSC_SCALE_XP001
	} lssc_scale_t;

	// 16-bit link status layout, msb first
	typedef struct packed {
		logic [2:0] reserved;
		logic       slot_clk;
		logic       training_active_flag;
		logic       training_fault_flag;
		logic [5:0] negotiated_lane_width;
		logic [3:0] link_rate_code;
	} lssc_link_state_t;

	// low 17 bits of slot caps, msb first
	typedef struct packed {
		lssc_scale_t power_limit_scale;
		logic [7:0]  power_limit_value;
		logic        hotplug_capable;
		logic        surprise_removal_ok;
		logic        power_lamp_present;
		logic        attn_lamp_present;
		logic        latch_sensor_present;
		logic        power_ctrl_present;
		logic        attn_button_present;
	} lssc_slot_caps_t;

	localparam lssc_slot_caps_t SLOT_CAPS_RST = '0;

	typedef struct packed {
		lssc_scale_t scale;
		logic [7:0]  value;
	} lssc_power_msg_t;

endpackage

// ===== lssc_regs.sv
// module: link status and slot capability registers with power limit messaging
// Behaviour
// - link rate field bits 3:0 always reads code 0x1.
// - bits 9:4 report negotiated lane width, read only.
// - bit 10 sets on a training error, resets to zero.
// - bit 11 reads one while link training is in progress.
// - bit 12 powers up from upstream strap on port 0, else downstream strap.
// - an EEPROM load may override the slot clock bit.
// - slot caps bits 4:0 mark button, controller, latch sensor, lamps; reset zero.
// - all slot caps fields read zero and are locked when slot not implemented.
// - slot caps bit 5 marks surprise removal allowed.
// - slot caps bit 6 marks hot-plug capable slot.
// - bits 14:7 hold the slot power limit value.
// - bits 16:15 select limit scale 1.0x, 0.1x, 0.01x, 0.001x.
// - every write of slot caps sends a power limit message.
// - data link going up sends a power limit message.
`timescale 1ns/1ps
`default_nettype none

module lssc_regs
	import lssc_pkg::*;
(
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// axi4-lite write address and data
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// link layer state
	input  wire logic [5:0]        negotiated_lane_width,
	input  wire logic              training_error,
	input  wire logic              training_active,
	input  wire logic              dl_up,
	// straps and port identity
	input  wire logic [1:0]        port_index,
	input  wire logic              upstream_shared_clk_strap,
	input  wire logic              downstream_shared_clk_strap,
	input  wire logic              port_capability_slot,
	// serial eeprom load of the slot clock bit
	input  wire logic              eeprom_load,
	input  wire logic              eeprom_slot_clk,
	// power limit message to the downstream device
	output logic                   power_msg_send,
	output lssc_power_msg_t        power_msg,
	// interrupt
	output logic                   irq
);

	logic [5:0]       width_q;
	logic             fault_q;
	logic             active_q;
	logic             slot_clk_q;
	logic             strap_done_q;
	logic             dl_up_q;
	lssc_slot_caps_t  caps_q;
	lssc_slot_caps_t  caps_d;
	logic [EV_W-1:0]  ev_status_q;
	logic [EV_W-1:0]  ev_mask_q;
	logic [EV_W-1:0]  ev_set;
	logic             wr_fire;
	logic             rd_fire;
	logic             caps_wr;
	logic             link_up_rise;
	lssc_link_state_t lsr_view;
	lssc_slot_caps_t  caps_view;
	logic [31:0]      rd_word;
	logic             rd_hit;
	logic             wr_hit;

	// ---------------- bus slave ----------------
	// both channels are taken together; simpler than independent latches and legal
	assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
	assign rd_fire = s_axi_arready && s_axi_arvalid;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else if (!s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end
	end

	always_comb begin
		wr_hit = 1'b0;
		case (s_axi_awaddr)
			LINK_STATE_REPORT_ADDR, SLOT_FEATURE_CAPS_ADDR,
			EVENT_STATUS_ADDR, EVENT_MASK_ADDR: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
		end
	end

	always_comb begin
		lsr_view = '0;
		lsr_view.link_rate_code = LINK_RATE_CODE;
		lsr_view.negotiated_lane_width = width_q;
		lsr_view.training_fault_flag = fault_q;
		lsr_view.training_active_flag = active_q;
		lsr_view.slot_clk = slot_clk_q;
		caps_view = port_capability_slot ? caps_q : SLOT_CAPS_RST;
	end

	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			LINK_STATE_REPORT_ADDR: rd_word = {16'h0000, lsr_view};
			SLOT_FEATURE_CAPS_ADDR: rd_word = {15'h0000, caps_view};
			EVENT_STATUS_ADDR:      rd_word = {29'h0000_0000, ev_status_q};
			EVENT_MASK_ADDR:        rd_word = {29'h0000_0000, ev_mask_q};
			default:                rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ---------------- link status ----------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			width_q  <= LANE_WIDTH_RST;
			active_q <= 1'b0;
		end else begin
			width_q  <= negotiated_lane_width;
			active_q <= training_active;
		end
	end

	// sticky: only reset clears it, bus writes never touch it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_q <= 1'b0;
		end else if (training_error) begin
			fault_q <= 1'b1;
		end
	end

	// strap sampled on the first edge after release, never under reset
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_done_q <= 1'b0;
			slot_clk_q   <= 1'b0;
		end else begin
			strap_done_q <= 1'b1;
			if (!strap_done_q) begin
				slot_clk_q <= (port_index == PORT_UPSTREAM) ?
					upstream_shared_clk_strap : downstream_shared_clk_strap;
			end else if (eeprom_load) begin
				slot_clk_q <= eeprom_slot_clk;
			end else if (wr_fire && s_axi_awaddr == LINK_STATE_REPORT_ADDR && s_axi_wstrb[1]) begin
				slot_clk_q <= s_axi_wdata[12];
			end
		end
	end

	// ---------------- slot capabilities ----------------
	assign caps_wr = wr_fire && s_axi_awaddr == SLOT_FEATURE_CAPS_ADDR;

	always_comb begin
		caps_d = caps_q;
		if (caps_wr && port_capability_slot) begin
			if (s_axi_wstrb[0]) caps_d[7:0] = s_axi_wdata[7:0];
			if (s_axi_wstrb[1]) caps_d[15:8] = s_axi_wdata[15:8];
			if (s_axi_wstrb[2]) caps_d[16] = s_axi_wdata[16];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			caps_q <= SLOT_CAPS_RST;
		end else begin
			caps_q <= caps_d;
		end
	end

	// ---------------- power limit message ----------------
	assign link_up_rise = dl_up && !dl_up_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dl_up_q <= 1'b0;
		end else begin
			dl_up_q <= dl_up;
		end
	end

	// message carries the fields as they stand after the write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_msg_send <= 1'b0;
			power_msg      <= '0;
		end else begin
			power_msg_send <= caps_wr || link_up_rise;
			if (caps_wr || link_up_rise) begin
				power_msg.value <= port_capability_slot ? caps_d.power_limit_value : 8'h00;
				power_msg.scale <= port_capability_slot ? caps_d.power_limit_scale
					: LSSC_SCALE_X1;
			end
		end
	end

	// ---------------- events and interrupt ----------------
	assign ev_set = {link_up_rise, power_msg_send, training_error};

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_status_q <= EVENT_RST;
			ev_mask_q   <= EVENT_RST;
		end else begin
			if (wr_fire && s_axi_awaddr == EVENT_STATUS_ADDR && s_axi_wstrb[0]) begin
				ev_status_q <= (ev_status_q & ~s_axi_wdata[EV_W-1:0]) | ev_set;
			end else begin
				ev_status_q <= ev_status_q | ev_set;
			end
			if (wr_fire && s_axi_awaddr == EVENT_MASK_ADDR && s_axi_wstrb[0]) begin
				ev_mask_q <= s_axi_wdata[EV_W-1:0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(ev_status_q & ev_mask_q);
		end
	end

	// ---------------- assertions ----------------
	property p_rate_read;
		@(posedge sys_clk) disable iff (!rst_n)
		(rd_fire && s_axi_araddr == LINK_STATE_REPORT_ADDR) |=> (s_axi_rdata[3:0] == 4'h1);
	endproperty
	a_rate_read: assert property (p_rate_read) else $error("link rate code not 0x1");

	property p_width;
		@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> (width_q == $past(negotiated_lane_width));
	endproperty
	a_width: assert property (p_width) else $error("lane width not reported");

	property p_fault;
		@(posedge sys_clk) disable iff (!rst_n)
		training_error |=> fault_q [*2];
	endproperty
	a_fault: assert property (p_fault) else $error("training fault not held");

	property p_active;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(training_active) |=> $rose(active_q);
	endproperty
	a_active: assert property (p_active) else $error("training flag not following");

	property p_strap;
		@(posedge sys_clk) disable iff (!rst_n)
		(!strap_done_q && port_index == PORT_UPSTREAM)
			|=> (slot_clk_q == $past(upstream_shared_clk_strap));
	endproperty
	a_strap: assert property (p_strap) else $error("slot clock not from upstream strap");

	property p_eeprom;
		@(posedge sys_clk) disable iff (!rst_n)
		(strap_done_q && eeprom_load) |=> (slot_clk_q == $past(eeprom_slot_clk));
	endproperty
	a_eeprom: assert property (p_eeprom) else $error("eeprom load ignored");

	property p_caps_zero;
		@(posedge sys_clk) disable iff (!rst_n)
		(rd_fire && s_axi_araddr == SLOT_FEATURE_CAPS_ADDR && !port_capability_slot)
			|=> (s_axi_rdata == 32'h0000_0000);
	endproperty
	a_caps_zero: assert property (p_caps_zero) else $error("slot caps visible when absent");

	property p_msg_write;
		@(posedge sys_clk) disable iff (!rst_n)
		caps_wr |=> (power_msg_send && power_msg.value == caps_view.power_limit_value
			&& power_msg.scale == caps_view.power_limit_scale);
	endproperty
	a_msg_write: assert property (p_msg_write) else $error("no message after caps write");

	property p_msg_link;
		@(posedge sys_clk) disable iff (!rst_n)
		(dl_up && !dl_up_q) |=> power_msg_send;
	endproperty
	a_msg_link: assert property (p_msg_link) else $error("no message on link up");

	property p_reserved;
		@(posedge sys_clk) disable iff (!rst_n)
		(rd_fire && s_axi_araddr == LINK_STATE_REPORT_ADDR) |=> (s_axi_rdata[31:13] == 19'h00000);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved link bits set");

endmodule // lssc_regs

`default_nettype wire

// ===== lssc_msg_sink.sv
// downstream device model taking in slot power limit messages
`timescale 1ns/1ps
`default_nettype none
module lssc_msg_sink
	import lssc_pkg::*;
(
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// message wires
	input  wire logic             power_msg_send,
	input  wire lssc_power_msg_t  power_msg,
	// what has arrived
	output var int                n_msg,
	output var lssc_power_msg_t   last_msg
);
	// each pulse is one whole message
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			n_msg    <= 0;
			last_msg <= '0;
		end else if (power_msg_send) begin
			n_msg    <= n_msg + 1;
			last_msg <= power_msg;
		end
	end
endmodule // lssc_msg_sink
`default_nettype wire

// ===== tb.sv
// testbench of the link status and slot caps bank
`timescale 1ns/1ps
`default_nettype none
module tb;
	import lssc_pkg::*;
	logic              sys_clk, rst_n, power_msg_send, irq, dl_up;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata, r;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp, rsp, port_index;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic              s_axi_rvalid, s_axi_rready, training_error, training_active;
	logic [5:0]        negotiated_lane_width;
	logic              upstream_shared_clk_strap, downstream_shared_clk_strap;
	logic              eeprom_load, eeprom_slot_clk, port_capability_slot;
	lssc_power_msg_t   power_msg, last_msg;
	int                n_msg, n_fail, compares, cyc;

	lssc_regs dut (
		.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .negotiated_lane_width,
		.training_error, .training_active, .dl_up, .port_index,
		.upstream_shared_clk_strap, .downstream_shared_clk_strap,
		.port_capability_slot, .eeprom_load, .eeprom_slot_clk, .power_msg_send,
		.power_msg, .irq
	);
	lssc_msg_sink sink (.sys_clk, .rst_n, .power_msg_send, .power_msg, .n_msg, .last_msg);

	task automatic conclude();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// each channel drops only at its own handshake edge
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		rsp = s_axi_bresp;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		r = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	function automatic logic [31:0] ls(input logic c, a, f, input logic [5:0] w);
		return {19'h0, c, a, f, w, 4'h1};
	endfunction
	task automatic mc(input int n, input logic [9:0] v);
		// dl_up rise reaches the sink two edges on; the third edge shows its count
		repeat (3) @(posedge sys_clk);
		chk(n_msg, n);
		chk(last_msg, v);
	endtask
	task automatic ic(input logic e);
		repeat (2) @(posedge sys_clk);
		chk(irq, e);
	endtask

	task automatic t_reset(input logic [1:0] p, input logic c);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		port_index <= p;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(LINK_STATE_REPORT_ADDR);
		chk(r, ls(c, 1'b0, 1'b0, negotiated_lane_width));
		rd(SLOT_FEATURE_CAPS_ADDR);
		chk(r, 32'h0);
	endtask
	task automatic t_link();
		negotiated_lane_width <= 6'h3F;
		training_active <= 1'b1;
		training_error <= 1'b1;
		@(posedge sys_clk);
		training_error <= 1'b0;
		rd(LINK_STATE_REPORT_ADDR);
		chk(r, ls(1'b1, 1'b1, 1'b1, 6'h3F));
		wr(LINK_STATE_REPORT_ADDR, 32'hFFFF_F00E);
		rd(LINK_STATE_REPORT_ADDR);
		chk(r, ls(1'b1, 1'b1, 1'b1, 6'h3F));
		training_active <= 1'b0;
		eeprom_load <= 1'b1;
		@(posedge sys_clk);
		eeprom_load <= 1'b0;
		rd(LINK_STATE_REPORT_ADDR);
		chk(r, ls(1'b0, 1'b0, 1'b1, 6'h3F));
	endtask
	task automatic t_caps();
		logic [31:0] e;
		int b;
		b = n_msg;
		for (int s = 0; s < 4; s++) begin
			e = {15'h0, s[1:0], 8'h81 + 8'(s), s[0] ? 7'h2A : 7'h55};
			wr(SLOT_FEATURE_CAPS_ADDR, e | 32'hFFFE_0000);
			mc(b + s + 1, e[16:7]);
			rd(SLOT_FEATURE_CAPS_ADDR);
			chk(r, e);
		end
		// low byte lane only: scale and upper value bits must survive
		s_axi_wstrb <= 4'h1;
		wr(SLOT_FEATURE_CAPS_ADDR, 32'h0000_0000);
		s_axi_wstrb <= 4'hF;
		mc(b + 5, 10'h384);
		rd(SLOT_FEATURE_CAPS_ADDR);
		chk(r, 32'h0001_C200);
	endtask
	task automatic t_dlup();
		int b;
		b = n_msg;
		dl_up <= 1'b1;
		mc(b + 1, 10'h384);
		repeat (3) @(posedge sys_clk);
		dl_up <= 1'b0;
		mc(b + 1, 10'h384);
	endtask
	task automatic t_noslot();
		int b;
		b = n_msg;
		port_capability_slot <= 1'b0;
		rd(SLOT_FEATURE_CAPS_ADDR);
		chk(r, 32'h0);
		wr(SLOT_FEATURE_CAPS_ADDR, 32'h0001_FFFF);
		mc(b + 1, 10'h000);
		rd(SLOT_FEATURE_CAPS_ADDR);
		chk(r, 32'h0);
		port_capability_slot <= 1'b1;
		// write while locked must not have landed
		rd(SLOT_FEATURE_CAPS_ADDR);
		chk(r, 32'h0001_C200);
	endtask
	task automatic t_irq();
		wr(EVENT_STATUS_ADDR, 32'h7);
		wr(EVENT_MASK_ADDR, 32'h1);
		ic(1'b0);
		training_error <= 1'b1;
		@(posedge sys_clk);
		training_error <= 1'b0;
		ic(1'b1);
		wr(EVENT_MASK_ADDR, 32'h0);
		ic(1'b0);
		wr(EVENT_MASK_ADDR, 32'h1);
		ic(1'b1);
		wr(EVENT_STATUS_ADDR, 32'h1);
		ic(1'b0);
		// index used as byte address must miss the map
		wr(12'h052, 32'hFFFF_FFFF);
		chk(rsp, RESP_SLVERR);
		rd(12'h052);
		chk({rsp, r[29:0]}, {RESP_SLVERR, 30'h0});
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			conclude();
		end
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, rst_n, port_index, dl_up} = '0;
		{training_error, training_active, eeprom_load, eeprom_slot_clk} = '0;
		{downstream_shared_clk_strap, n_fail, compares, cyc} = '0;
		s_axi_wstrb = 4'hF;
		upstream_shared_clk_strap = 1'b1;
		port_capability_slot = 1'b1;
		negotiated_lane_width = 6'h04;
		t_reset(2'h0, 1'b1);
		t_link();
		t_caps();
		t_dlup();
		t_noslot();
		t_irq();
		t_reset(2'h2, 1'b0);
		conclude();
	end
endmodule // tb
`default_nettype wire
